/* File: rtl/frme_engine.sv */
`timescale 1ns/100ps
`default_nettype none
module frme_engine
	import frme_pkg::*;
#(
	parameter int unsigned AW = 8
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output var  logic [31:0]        prdata,
	output var  logic               pready,
	output var  logic               pslverr,
	// Flash link pins
	input  wire logic               ce_n,
	input  wire logic               oe_n,
	input  wire logic               le_n,
	input  wire logic               bus_clk,
	input  wire logic [AW-1:0]      addr_in,
	output var  logic [DW-1:0]      data_out,
	output var  logic               data_oe,
	output var  logic               stall_out,
	output var  logic               stall_oe
);
	if (AW < 5 || AW > 24) begin : g_bad_aw
		$error("AW must lie between 5 and 24");
	end

	function automatic logic [3:0] bl_mask(input logic [2:0] bl);
		if (bl == BL_4)
			return 4'h3;
		else if (bl == BL_8)
			return 4'h7;
		else
			return 4'hF;
	endfunction : bl_mask

	function automatic logic [AW-1:0] next_addr(
		input logic [AW-1:0] a,
		input logic [AW-1:0] m,
		input logic          wrap);
		logic [AW-1:0] inc;
		inc = a + 1'b1;
		return wrap ? ((a & ~m) | (inc & m)) : inc;
	endfunction : next_addr

	logic [3+AW:0] sync_q;
	frme_pins_s    pin_s;
	frme_pins_s    pin_q;
	logic [AW-1:0] addr_s;
	logic [AW-1:0] addr_q;
	frme_cfg_s     cfg;
	frme_src_e     src;
	logic [AW-1:0] maddr;
	frme_st_e      st;
	logic [AW-1:0] baddr;
	logic [1:0]    start_off;
	logic [2:0]    lat_cnt;
	logic [4:0]    words_left;
	logic [1:0]    stall_cnt;
	logic          hold_cnt;
	logic          cross_done;
	logic          pu_pend;
	logic [1:0]    pu_cnt;
	logic [7:0]    acc_cnt;
	logic [AW-3:0] page_tag;
	logic          page_ok;
	logic [7:0]    idle_cnt;
	logic          standby;
	logic [DW-1:0] mem_q;
	logic [DW-1:0] word;
	logic [31:0]   rd_val;
	logic          rd_hit;
	logic          stall_act;

	frme_sync #(
		.W (4 + AW)
	) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({{ce_n, oe_n, le_n, bus_clk} ^ 4'hE, addr_in}),
		.q     (sync_q)
	);

	// Enables cross inverted so the cleared synchroniser reads idle pins
	assign pin_s  = sync_q[3+AW -: 4] ^ 4'hE;
	assign addr_s = sync_q[AW-1:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q  <= 4'hE;
			addr_q <= '0;
		end else begin
			pin_q  <= pin_s;
			addr_q <= addr_s;
		end
	end

	logic          async;
	logic          cont;
	logic          wrap_act;
	logic          single;
	logic [AW-1:0] amask;
	logic          rise;
	logic          v_edge;
	logic          start_ev;
	logic          pu_cond;
	logic          pu_go;
	logic          go;
	logic          adv;
	logic          cross_ev;
	logic          dvalid;
	logic          act;
	logic          a_load;

	assign async    = cfg.read_mode_select;
	assign cont     = cfg.burst_length_field == BL_CONT;
	assign wrap_act = !cfg.wrap_select && !cont;
	assign single   = src != SRC_ARRAY;
	assign amask    = AW'(bl_mask(cfg.burst_length_field));
	assign rise     = pin_s.clk && !pin_q.clk;
	// Valid edge follows the edge select bit
	assign v_edge   = cfg.valid_edge_select ? rise
		: (!pin_s.clk && pin_q.clk);
	// Later of the two enable falls arms the burst
	assign start_ev = !pin_s.le_n && !pin_s.ce_n
		&& (pin_q.le_n || pin_q.ce_n);
	assign pu_cond  = rise && !pin_s.ce_n && !pin_s.oe_n
		&& pin_s.le_n && !stall_oe;
	assign pu_go    = pu_pend && pu_cond && !async
		&& pu_cnt == PU_LAST_EDGE;
	// A halted clock gives no edges, so the burst simply waits
	assign go       = v_edge && !async && !pin_s.ce_n && !pu_go
		&& !start_ev;
	assign adv      = go && st == S_DATA && stall_cnt == 2'h0
		&& !hold_cnt && !single && (cont || words_left != 5'h01);
	assign cross_ev = adv && !wrap_act && !cross_done
		&& baddr[3:0] == BND16_LAST;
	assign dvalid   = st == S_DATA && stall_cnt == 2'h0;
	assign act      = addr_s != addr_q || pin_s.ce_n != pin_q.ce_n
		|| pin_s.oe_n != pin_q.oe_n || pin_s.le_n != pin_q.le_n;
	assign a_load   = async && !pin_s.ce_n && acc_cnt == 8'h01;

	// APB slave: no wait states, answer registered at setup
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		if (paddr == REG_CFG) begin
			rd_val = {16'h0000, cfg};
		end else if (paddr == REG_CMD) begin
			rd_val = {30'h0000_0000, src};
		end else if (paddr == REG_STAT) begin
			rd_val = 32'(baddr) << STAT_ADDR;
			rd_val[STAT_STBY] = standby;
			rd_val[STAT_BUSY] = st != S_IDLE;
			rd_val[STAT_SUSP] = st != S_IDLE && pin_s.oe_n;
			rd_val[STAT_PU]   = pu_pend;
		end else if (paddr == REG_MADDR) begin
			rd_val = 32'(maddr);
		end else if (paddr != REG_MDATA) begin
			rd_hit = 1'b0;
		end
	end

	logic setup;
	logic apb_wr;
	logic mem_we;

	assign setup  = psel && !penable;
	assign apb_wr = psel && penable && pwrite && pready;
	assign mem_we = apb_wr && paddr == REG_MDATA;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !rd_hit;
			if (setup) begin
				prdata <= rd_val;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg   <= CFG_RST;
			src   <= SRC_ARRAY;
			maddr <= '0;
		end else if (apb_wr) begin
			if (paddr == REG_CFG) begin
				cfg <= frme_cfg_s'(pwdata[15:0]);
			end else if (paddr == REG_CMD) begin
				src <= frme_src_e'(pwdata[1:0]);
			end else if (paddr == REG_MADDR) begin
				maddr <= pwdata[AW-1:0];
			end else if (paddr == REG_MDATA) begin
				maddr <= maddr + 1'b1;
			end
		end
	end

	// Sensing runs on every cycle, suspended or not
	frme_mem #(
		.AW (AW),
		.DW (DW)
	) u_mem (
		.clk   (pclk),
		.we    (mem_we),
		.waddr (maddr),
		.wdata (pwdata[DW-1:0]),
		.raddr (async ? addr_s : baddr),
		.rdata (mem_q)
	);

	always_comb begin
		case (src)
			SRC_STATUS: word = STATUS_READY;
			SRC_QUERY:  word = QUERY_VALUE;
			SRC_SIG:    word = SIG_VALUE;
			default:    word = mem_q;
		endcase
	end

	// Power-up address capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pu_pend <= 1'b1;
			pu_cnt  <= 2'h0;
		end else if (pu_go) begin
			pu_pend <= 1'b0;
		end else if (pu_pend && pu_cond) begin
			pu_cnt <= pu_cnt + 1'b1;
		end
	end

	// Synchronous burst sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st         <= S_IDLE;
			baddr      <= '0;
			start_off  <= 2'h0;
			lat_cnt    <= 3'h0;
			words_left <= 5'h00;
			stall_cnt  <= 2'h0;
			hold_cnt   <= 1'b0;
			cross_done <= 1'b0;
		end else if (async || pin_s.ce_n) begin
			st        <= S_IDLE;
			stall_cnt <= 2'h0;
			hold_cnt  <= 1'b0;
		end else if (pu_go || (go && st == S_ARM)) begin
			st         <= S_LAT;
			baddr      <= addr_s;
			start_off  <= addr_s[1:0];
			lat_cnt    <= cfg.first_data_latency;
			words_left <= 5'(bl_mask(cfg.burst_length_field)) + 5'h01;
			cross_done <= 1'b0;
		end else if (start_ev) begin
			st <= S_ARM;
		end else if (go) begin
			case (st)
				S_LAT: begin
					if (lat_cnt <= 3'h1) begin
						st       <= S_DATA;
						hold_cnt <= cfg.data_hold_select;
					end else begin
						lat_cnt <= lat_cnt - 3'h1;
					end
				end
				S_DATA: begin
					if (stall_cnt != 2'h0) begin
						stall_cnt <= stall_cnt - 2'h1;
						hold_cnt  <= cfg.data_hold_select;
					end else if (hold_cnt) begin
						hold_cnt <= 1'b0;
					end else if (single) begin
						// Same word again until the cycle ends
						hold_cnt <= cfg.data_hold_select;
					end else if (!adv) begin
						st <= S_END;
					end else begin
						// Carries past bank edges freely
						baddr      <= next_addr(baddr, amask,
							wrap_act);
						words_left <= words_left - 5'h01;
						hold_cnt   <= cfg.data_hold_select;
						if (cross_ev) begin
							cross_done <= 1'b1;
							stall_cnt  <= start_off;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Asynchronous page timing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_cnt  <= 8'h00;
			page_tag <= '0;
			page_ok  <= 1'b0;
		end else if (!async || pin_s.ce_n) begin
			acc_cnt <= 8'h00;
			page_ok <= 1'b0;
		end else if (addr_s != addr_q || pin_q.ce_n) begin
			page_tag <= addr_s[AW-1:2];
			page_ok  <= 1'b1;
			if (page_ok && addr_s[AW-1:2] == page_tag)
				acc_cnt <= 8'(PAGE_CYC);
			else
				acc_cnt <= 8'(RAND_CYC);
		end else if (acc_cnt != 8'h00) begin
			acc_cnt <= acc_cnt - 8'h01;
		end
	end

	// Standby only lowers power; drivers stay as they are
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt <= 8'h00;
			standby  <= 1'b0;
		end else if (!async || act) begin
			idle_cnt <= 8'h00;
			standby  <= 1'b0;
		end else if (idle_cnt == 8'(STBY_CYC - 1)) begin
			standby <= 1'b1;
		end else begin
			idle_cnt <= idle_cnt + 8'h01;
		end
	end

	always_comb begin
		if (async)
			stall_act = cfg.stall_function_select;
		else if (cfg.stall_function_select)
			stall_act = dvalid;
		else
			stall_act = st != S_IDLE && !dvalid
				&& !pin_s.oe_n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out  <= '0;
			data_oe   <= 1'b0;
			stall_out <= 1'b0;
			stall_oe  <= 1'b0;
		end else begin
			if (a_load || (!async && dvalid)) begin
				data_out <= word;
			end
			data_oe   <= !pin_s.ce_n && !pin_s.oe_n;
			stall_out <= cfg.stall_polarity ? stall_act
				: !stall_act;
			// Released while power-up waits so the line reads high
			stall_oe  <= !pu_pend && !pin_s.ce_n
				&& !pin_s.oe_n;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_pu_third;
		pu_pend && pu_cond && !async && pu_cnt == PU_LAST_EDGE;
	endsequence

	property p_pu_capture;
		s_pu_third |=> st == S_LAT && !pu_pend && baddr == $past(addr_s);
	endproperty
	a_pu_capture: assert property (p_pu_capture)
		else $error("power-up capture missed");

	property p_bus_drive;
		1'b1 |=> data_oe == $past(!pin_s.ce_n && !pin_s.oe_n);
	endproperty
	a_bus_drive: assert property (p_bus_drive)
		else $error("data bus drive wrong");

	property p_stall_release;
		pin_s.oe_n |=> !stall_oe;
	endproperty
	a_stall_release: assert property (p_stall_release)
		else $error("stall line not released");

	property p_async_quiet;
		(async && !cfg.stall_function_select) ##1 $stable(cfg)
			|-> stall_out != cfg.stall_polarity;
	endproperty
	a_async_quiet: assert property (p_async_quiet)
		else $error("stall asserted in async mode");

	property p_lat_stall;
		(st == S_LAT && !cfg.stall_function_select && !pin_s.oe_n)
			##1 $stable(cfg) |-> stall_out == cfg.stall_polarity;
	endproperty
	a_lat_stall: assert property (p_lat_stall)
		else $error("stall not asserted in latency");

	property p_standby;
		(idle_cnt == 8'(STBY_CYC - 1) && async && !act) |=> standby;
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby not entered");

	property p_single_hold;
		(dvalid && single) ##1 (dvalid && single && $stable(src))
			|=> $stable(data_out);
	endproperty
	a_single_hold: assert property (p_single_hold)
		else $error("single read word changed");

	property p_wrap_high;
		(adv && wrap_act) |=> (baddr & ~$past(amask))
			== ($past(baddr) & ~$past(amask));
	endproperty
	a_wrap_high: assert property (p_wrap_high)
		else $error("wrap touched high address bits");

	property p_cross_stall;
		cross_ev |=> stall_cnt == $past(start_off) && cross_done;
	endproperty
	a_cross_stall: assert property (p_cross_stall)
		else $error("boundary stall length wrong");

	property p_hold_load;
		(go && st == S_LAT && lat_cnt <= 3'h1)
			|=> st == S_DATA && hold_cnt == $past(cfg.data_hold_select);
	endproperty
	a_hold_load: assert property (p_hold_load)
		else $error("first word hold wrong");
endmodule : frme_engine
`default_nettype wire

/* File: rtl/frme_pkg.sv */
// What this block does
// - Power-up: latch address on third qualified rise
// - Async reads ignore clock, source by command
// - Async page of four words, faster hits
// - Async idle time enters standby, outputs driven
// - Async mode keeps stall line deasserted unless function bit one
// - Burst starts first valid edge after enables
// - Burst increments address after first-data latency
// - Burst length four, eight, sixteen or continuous
// - Each word holds one or two cycles
// - Burst wraps in boundary or continues past
// - Stall asserted in latency, waits, burst end
// - Continuous burst waits at first sixteen crossing
// - Aligned start gives same wrap/no-wrap sequence
// - Polarity bit selects stall active level
// - Suspend anytime, sensing continues, data kept
// - Host halts clock, raises oe; resume in place
// - Gated stall line floats once oe high
// - Single synchronous read repeats one word
// - Non-array reads stall same, release on data
// - All banks read both ways, bursts cross
// - Wrap bit zero wraps, one does not
// - Function bit zero gives stall behaviour
// - Crossing stall lasts start offset, only once
package frme_pkg;
	localparam int unsigned DW      = 16;
	localparam int unsigned PADDR_W = 8;

	localparam logic [7:0] REG_CFG   = 8'h00;
	localparam logic [7:0] REG_CMD   = 8'h04;
	localparam logic [7:0] REG_STAT  = 8'h08;
	localparam logic [7:0] REG_MADDR = 8'h0C;
	localparam logic [7:0] REG_MDATA = 8'h10;

	localparam int unsigned STAT_STBY = 0;
	localparam int unsigned STAT_BUSY = 1;
	localparam int unsigned STAT_SUSP = 2;
	localparam int unsigned STAT_PU   = 3;
	localparam int unsigned STAT_ADDR = 8;

	localparam int unsigned CLK_NS   = 20;
	localparam int unsigned STBY_NS  = 150;
	localparam int unsigned RAND_NS  = 100;
	localparam int unsigned PAGE_NS  = 40;
	localparam int unsigned STBY_CYC = (STBY_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned RAND_CYC = (RAND_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PAGE_CYC = (PAGE_NS + CLK_NS - 1) / CLK_NS;

	localparam logic [1:0] PU_LAST_EDGE = 2'h2;
	localparam logic [3:0] BND16_LAST   = 4'hF;

	localparam logic [2:0] BL_4    = 3'h1;
	localparam logic [2:0] BL_8    = 3'h2;
	localparam logic [2:0] BL_16   = 3'h3;
	localparam logic [2:0] BL_CONT = 3'h7;

	// Status word returned to the link whenever the command selects the status source
	localparam logic [15:0] STATUS_READY = 16'h0080;
	// Arbitrary values, not tied to any real part
	localparam logic [15:0] SIG_VALUE    = 16'hA5C3;
	localparam logic [15:0] QUERY_VALUE  = 16'h3C5A;

	typedef enum logic [1:0] {
		SRC_ARRAY, SRC_STATUS, SRC_QUERY, SRC_SIG
	} frme_src_e;

	typedef enum {S_IDLE, S_ARM, S_LAT, S_DATA, S_END} frme_st_e;

	typedef struct packed {
		logic       read_mode_select;
		logic       rsv14;
		logic [2:0] first_data_latency;
		logic       stall_polarity;
		logic       data_hold_select;
		logic [1:0] rsv8_7;
		logic       valid_edge_select;
		logic       rsv5;
		logic       stall_function_select;
		logic       wrap_select;
		logic [2:0] burst_length_field;
	} frme_cfg_s;

	localparam frme_cfg_s CFG_RST = 16'h1C4F;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic le_n;
		logic clk;
	} frme_pins_s;
endpackage : frme_pkg

/* File: rtl/frme_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module frme_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : frme_sync
`default_nettype wire

/* File: rtl/frme_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module frme_mem #(
	parameter int unsigned AW = 8,
	parameter int unsigned DW = 16
) (
	// Clock
	input  wire logic          clk,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	// Read port
	input  wire logic [AW-1:0] raddr,
	output var  logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : frme_mem
`default_nettype wire

/* File: test/frme_host.sv */
`timescale 1ns/100ps
`default_nettype none
module frme_host (
	// Clock
	input  wire logic       pclk,
	// Link pins
	output var  logic       ce_n,
	output var  logic       oe_n,
	output var  logic       le_n,
	output var  logic       bus_clk,
	output var  logic [7:0] addr_in
);
	initial begin
		ce_n    = 1'b1;
		oe_n    = 1'b1;
		le_n    = 1'b1;
		bus_clk = 1'b0;
		addr_in = 8'hFF;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// Released lines show the inverse so a stale address never matches
	task automatic idle();
		ce_n    <= 1'b1;
		oe_n    <= 1'b1;
		le_n    <= 1'b1;
		bus_clk <= 1'b0;
		addr_in <= ~addr_in;
		cyc(8);
	endtask : idle

	// Power-up keeps the latch enable high, a burst pulls it low
	task automatic start(input logic [7:0] a, input logic pu);
		addr_in <= a;
		ce_n    <= 1'b0;
		oe_n    <= 1'b0;
		le_n    <= pu;
		cyc(6);
	endtask : start

	// Clock only runs inside a frame and halts low
	task automatic tick();
		bus_clk <= 1'b1;
		cyc(4);
		bus_clk <= 1'b0;
		cyc(4);
	endtask : tick

	task automatic unlatch();
		le_n    <= 1'b1;
		addr_in <= ~addr_in;
	endtask : unlatch

	// Suspend only while the clock stands still
	task automatic oe(input logic v);
		oe_n <= v;
		cyc(6);
	endtask : oe

	task automatic aread(input logic [7:0] a);
		addr_in <= a;
		ce_n    <= 1'b0;
		oe_n    <= 1'b0;
		@(posedge pclk);
	endtask : aread
endmodule : frme_host
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import frme_pkg::*;
	localparam int SREADY = 65536 + int'(STATUS_READY);
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        ce_n, oe_n, le_n, bus_clk, data_oe, stall_out, stall_oe;
	logic [7:0]  addr_in;
	logic [15:0] data_out;
	logic        pol;
	int          miscompares, checks_done;
	logic [15:0] srcv [4] = '{16'h0000, STATUS_READY, QUERY_VALUE, SIG_VALUE};

	frme_engine #(.AW(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
		.oe_n(oe_n), .le_n(le_n), .bus_clk(bus_clk), .addr_in(addr_in),
		.data_out(data_out), .data_oe(data_oe), .stall_out(stall_out),
		.stall_oe(stall_oe));
	frme_host u_host (.pclk(pclk), .ce_n(ce_n), .oe_n(oe_n), .le_n(le_n),
		.bus_clk(bus_clk), .addr_in(addr_in));

	always #10 pclk = ~pclk;

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic chk(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk(n < 20, "no pready");
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Let an edge pass so a following call never re-drives psel at once
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
		chk(er === 1'b0, "write refused");
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 32'h0000_0000, rd, er);
		chk(rd === e && er === ee, $sformatf("read %h got %h", a, rd));
	endtask : rdc

	function automatic logic [15:0] wd(input int a);
		return {8'hA5, a[7:0]};
	endfunction : wd

	function automatic int xv(input int e);
		if (e < 0)
			return e;
		if (e < 256)
			return int'(wd(e));
		return e - 65536;
	endfunction : xv

	// Codes: -2 stall line released, -1 stall asserted, -3 nothing valid
	function automatic int code();
		if (stall_oe === 1'b0)
			return -2;
		if (stall_oe === 1'b1 && stall_out === pol)
			return -1;
		if (data_oe === 1'b1 && stall_out === ~pol && (^data_out) !== 1'bx)
			return int'(data_out);
		return -3;
	endfunction : code

	task automatic waitv(input logic [15:0] v, output int n);
		n = 0;
		while (!(data_oe === 1'b1 && data_out === v) && n < 40) begin
			@(posedge pclk);
			n++;
		end
	endtask : waitv

	task automatic burst(input string nm, input logic [15:0] cf,
		input logic [7:0] a, input logic pu, input int sus, input int exp[$]);
		wr(REG_CFG, {16'h0000, cf});
		pol = cf[10];
		u_host.start(a, pu);
		foreach (exp[i]) begin
			u_host.tick();
			if (i == 0 && !pu)
				u_host.unlatch();
			chk(code() == xv(exp[i]), $sformatf("%s step %0d got %0d", nm, i, code()));
			if (i == sus) begin
				u_host.oe(1'b1);
				chk(data_oe === 1'b0 && stall_oe === 1'b0, "suspend drives");
				u_host.oe(1'b0);
			end
		end
		u_host.idle();
		$display("test %s done", nm);
	endtask : burst

	task automatic t_regs();
		rdc(REG_CFG, 32'h0000_1C4F, 1'b0);
		wr(REG_MADDR, 32'h0000_0000);
		for (int i = 0; i < 32; i++)
			wr(REG_MDATA, {16'h0000, wd(i)});
		rdc(8'h3C, 32'h0000_0000, 1'b1);
		rdc(REG_MDATA, 32'h0000_0000, 1'b0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_async();
		int          tr;
		int          tp;
		logic [31:0] rd;
		logic        er;
		wr(REG_CFG, 32'h0000_9C4F);
		pol = 1'b1;
		u_host.aread(8'h04);
		waitv(wd(4), tr);
		u_host.aread(8'h05);
		waitv(wd(5), tp);
		chk(tr < 40 && tp < tr, "page hit not faster");
		chk(stall_oe === 1'b0 || stall_out === 1'b0, "stall in async");
		repeat (12) @(posedge pclk);
		apb(1'b0, REG_STAT, 32'h0000_0000, rd, er);
		chk(rd[STAT_STBY] === 1'b1 && data_oe === 1'b1 && data_out === wd(5), "standby");
		for (int s = 1; s < 4; s++) begin
			wr(REG_CMD, s);
			u_host.aread(8'h06 + s[7:0]);
			waitv(srcv[s], tr);
			chk(tr < 40, "source value");
		end
		wr(REG_CMD, 32'h0000_0000);
		u_host.oe(1'b1);
		chk(data_oe === 1'b0, "bus driven with oe high");
		u_host.idle();
		$display("test async done");
	endtask : t_async

	// Whole run is about a thousand cycles; twenty thousand means a hang
	initial begin
		#400_000;
		miscompares++;
		end_sim();
	end

	initial begin
		pclk    = 1'b0;
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		pol     = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		burst("powerup", 16'h1C4F, 8'h05, 1'b1, -1, '{-2, -2, -1, -1, -1, 5, 6});
		burst("cont13", 16'h1C4F, 8'd13, 1'b0, -1, '{-1, -1, -1, 13, 14, 15, -1, 16, 17});
		burst("wrap4", 16'h1C41, 8'd2, 1'b0, -1, '{-1, -1, -1, 2, 3, 0, 1, -1});
		burst("nowrap4", 16'h1C49, 8'd14, 1'b0, -1, '{-1, -1, -1, 14, 15, -1, -1, 16, 17, -1});
		burst("wrap8", 16'h1C42, 8'd8, 1'b0, -1, '{-1, -1, -1, 8, 9, 10, 11, 12, 13, 14, 15, -1});
		burst("nowrap8", 16'h1C4A, 8'd8, 1'b0, -1, '{-1, -1, -1, 8, 9, 10, 11, 12, 13, 14, 15, -1});
		burst("hold", 16'h1E4F, 8'd0, 1'b0, -1, '{-1, -1, -1, 0, 0, 1, 1});
		burst("pol", 16'h184F, 8'd14, 1'b0, -1, '{-1, -1, -1, 14, 15, -1, -1, 16, 17});
		burst("suspend", 16'h1C4F, 8'd0, 1'b0, 4, '{-1, -1, -1, 0, 1, 2, 3});
		wr(REG_CMD, 32'h0000_0001);
		burst("single", 16'h1C4F, 8'd0, 1'b0, -1, '{-1, -1, -1, SREADY, SREADY, SREADY});
		wr(REG_CMD, 32'h0000_0000);
		t_async();
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
